// File: pkg/ihrp_map.svh
// offsets, field positions, reset values and timing counts of the host port
`ifndef IHRP_MAP_SVH
`define IHRP_MAP_SVH

// ---------------------------------------------------------------
// host register select codes
// ---------------------------------------------------------------
`define IHRP_SEL_ADDR_LOW 2'h0
`define IHRP_SEL_ADDR_HIGH 2'h1
`define IHRP_SEL_DATA 2'h2
`define IHRP_SEL_DATA_INC 2'h3

// ---------------------------------------------------------------
// special values and field positions
// ---------------------------------------------------------------
`define IHRP_HW_RESET_PATTERN 8'h40
`define IHRP_ADDR_RESET 16'h0000
`define IHRP_ADDR_STEP 16'h0001
`define IHRP_DEFAULT_VALUE 8'h00
`define IHRP_CTRL_INDEX 16'h0008
`define IHRP_CTRL_SOFT_RESET_BIT 0
`define IHRP_NODE_BASE 16'h000C
`define IHRP_NODE_BYTES 6
`define IHRP_NODE_GROUP_BIT 40
`define IHRP_NODE_LOCAL_BIT 41

// ---------------------------------------------------------------
// timing: clock rate and the longest ready delay
// ---------------------------------------------------------------
`define IHRP_CLOCK_MHZ 10
`define IHRP_HOST_WAIT_NS 60
`define IHRP_HOST_WAIT_RAW ((`IHRP_HOST_WAIT_NS * `IHRP_CLOCK_MHZ) / 1000)
`define IHRP_HOST_WAIT_CYC ((`IHRP_HOST_WAIT_RAW < 1) ? 1 : `IHRP_HOST_WAIT_RAW)
`define IHRP_SLOT_COUNT 5
`define IHRP_HOST_SLOTS 2

// ---------------------------------------------------------------
// test port instruction codes
// ---------------------------------------------------------------
`define IHRP_IR_CAPTURE 2'h1
`define IHRP_IR_RESET 2'h3

`endif

// File: pkg/ihrp_pkg.sv
// types shared by the host register port design
package ihrp_pkg;

  // sampled host pins, carried as one word through the synchroniser
  typedef struct packed {
    logic cs_n;
    logic read_not_write;
    logic [1:0] sel;
    logic [7:0] data;
  } ihrp_pins_s;

  // host cycle sequencer
  typedef enum logic [2:0] {
    ST_RELEASE = 3'b000,
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_FETCH = 3'b011,
    ST_DONE = 3'b100
  } ihrp_state_e;

  // test port controller
  typedef enum logic [3:0] {
    TAP_RESET = 4'b0000, TAP_IDLE = 4'b0001, TAP_SEL_DR = 4'b0010,
    TAP_CAP_DR = 4'b0011, TAP_SHIFT_DR = 4'b0100, TAP_EXIT1_DR = 4'b0101,
    TAP_PAUSE_DR = 4'b0110, TAP_EXIT2_DR = 4'b0111, TAP_UPD_DR = 4'b1000,
    TAP_SEL_IR = 4'b1001, TAP_CAP_IR = 4'b1010, TAP_SHIFT_IR = 4'b1011,
    TAP_EXIT1_IR = 4'b1100, TAP_PAUSE_IR = 4'b1101, TAP_EXIT2_IR = 4'b1110,
    TAP_UPD_IR = 4'b1111
  } ihrp_tap_e;

endpackage

// File: core/ihrp_reg_mem.sv
// internal byte-wide register array with default restore and registered read
`include "ihrp_map.svh"

module ihrp_reg_mem import ihrp_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic i_clock,
  input wire logic i_clear_all,
  input wire logic i_clear_soft,
  input wire logic [ADDR_W-1:0] i_keep_index,
  input wire logic i_write,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic [DATA_W-1:0] o_rdata
);

  localparam int DEPTH = 1 << ADDR_W;

  // refused at elaboration: only byte-wide entries are served
  if (ADDR_W < 5 || ADDR_W > 16 || DATA_W != 8) begin : g_bad_geometry
    $error("ihrp_reg_mem: unsupported geometry");
  end

  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [DATA_W-1:0] mem_d [DEPTH];
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // ---------------------------------------------------------------
  // one entry per address; soft clear spares the kept entry
  // ---------------------------------------------------------------
  for (genvar g = 0; g < DEPTH; g++) begin : g_entry
    always_comb begin
      mem_d[g] = mem_q[g];
      if (i_clear_all) begin
        mem_d[g] = `IHRP_DEFAULT_VALUE;
      end else if (i_clear_soft && (ADDR_W'(g) != i_keep_index)) begin
        mem_d[g] = `IHRP_DEFAULT_VALUE;
      end else if (i_write && (i_addr == ADDR_W'(g))) begin
        mem_d[g] = i_wdata;
      end
    end
    always_ff @(posedge i_clock) begin
      mem_q[g] <= mem_d[g];
    end
  end

  // read port: data is valid one cycle after the address is presented
  always_comb begin
    rdata_d = mem_q[i_addr];
  end
  always_ff @(posedge i_clock) begin
    rdata_q <= rdata_d;
  end

  assign o_rdata = rdata_q;

endmodule // ihrp_reg_mem

// File: core/ihrp_test_port.sv
// test-port controller sampled on the system clock, reset by test reset
`include "ihrp_map.svh"

module ihrp_test_port import ihrp_pkg::*; (
  input wire logic i_clock,
  input wire logic i_test_reset_n,
  input wire logic i_test_clock,
  input wire logic i_test_mode,
  input wire logic i_test_din,
  output logic o_test_dout
);

  logic [2:0] tck_q, tms_q, tdi_q;
  logic tck_f_q, tms_f_q, tdi_f_q;
  ihrp_tap_e st_q, st_d;
  logic [1:0] ir_q, ir_d;
  logic byp_q, byp_d;
  logic tdo_q, tdo_d;
  logic rise, fall;

  // ---------------------------------------------------------------
  // pin sampling; the first stage is read only by the second
  // ---------------------------------------------------------------
  // async test reset
  always_ff @(posedge i_clock or negedge i_test_reset_n) begin
    if (!i_test_reset_n) begin
      tck_q <= 3'h0;
      tms_q <= 3'h7;
      tdi_q <= 3'h0;
      tck_f_q <= 1'b0;
      tms_f_q <= 1'b1;
      tdi_f_q <= 1'b0;
    end else begin
      tck_q <= {tck_q[1:0], i_test_clock};
      tms_q <= {tms_q[1:0], i_test_mode};
      tdi_q <= {tdi_q[1:0], i_test_din};
      if (tck_q[1] == tck_q[2]) tck_f_q <= tck_q[2];
      if (tms_q[1] == tms_q[2]) tms_f_q <= tms_q[2];
      if (tdi_q[1] == tdi_q[2]) tdi_f_q <= tdi_q[2];
    end
  end

  assign rise = (tck_q[1] == tck_q[2]) && tck_q[2] && !tck_f_q;
  assign fall = (tck_q[1] == tck_q[2]) && !tck_q[2] && tck_f_q;

  // ---------------------------------------------------------------
  // controller: states move on test clock rise, output on its fall
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    ir_d = ir_q;
    byp_d = byp_q;
    tdo_d = tdo_q;
    if (rise) begin
      case (st_q)
        TAP_RESET: st_d = tms_f_q ? TAP_RESET : TAP_IDLE;
        TAP_IDLE: st_d = tms_f_q ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR: st_d = tms_f_q ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: st_d = tms_f_q ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: st_d = tms_f_q ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR: st_d = tms_f_q ? TAP_UPD_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR: st_d = tms_f_q ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR: st_d = tms_f_q ? TAP_UPD_DR : TAP_SHIFT_DR;
        TAP_UPD_DR: st_d = tms_f_q ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR: st_d = tms_f_q ? TAP_RESET : TAP_CAP_IR;
        TAP_CAP_IR: st_d = tms_f_q ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: st_d = tms_f_q ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR: st_d = tms_f_q ? TAP_UPD_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR: st_d = tms_f_q ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR: st_d = tms_f_q ? TAP_UPD_IR : TAP_SHIFT_IR;
        TAP_UPD_IR: st_d = tms_f_q ? TAP_SEL_DR : TAP_IDLE;
        default: st_d = TAP_RESET;
      endcase
      // every instruction selects the one-bit bypass path
      if (st_q == TAP_CAP_DR) byp_d = 1'b0;
      if (st_q == TAP_SHIFT_DR) byp_d = tdi_f_q;
      if (st_q == TAP_CAP_IR) ir_d = `IHRP_IR_CAPTURE;
      if (st_q == TAP_SHIFT_IR) ir_d = {tdi_f_q, ir_q[1]};
    end
    if (fall) begin
      tdo_d = (st_q == TAP_SHIFT_IR) ? ir_q[0] : byp_q;
    end
  end

  always_ff @(posedge i_clock or negedge i_test_reset_n) begin
    if (!i_test_reset_n) begin
      st_q <= TAP_RESET;
      ir_q <= `IHRP_IR_RESET;
      byp_q <= 1'b0;
      tdo_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ir_q <= ir_d;
      byp_q <= byp_d;
      tdo_q <= tdo_d;
    end
  end

  assign o_test_dout = tdo_q;

endmodule // ihrp_test_port

// File: core/ihrp_port.sv
// indirect host register port: pointer registers, data windows, resets
//
// Functional notes
// - four byte registers chosen by select
// - data write goes to posted address
// - data read drives posted register out
// - read ready only after fetch completes
// - busy resource delays ready, bounded
// - two of five slots reserved for host
// - write ready after byte committed
// - incrementing window post-increments address
// - mixed reads and writes all increment
// - 0x40 to address high resets device
// - address low ignored during that reset
// - hardware reset restores every default
// - soft reset spares control register
// - node address in wire order, flags
// - first byte highest, low bit lowest
// - test reset acts asynchronously
// - read-not-write picks cycle direction
// - ready released while deselected
`include "ihrp_map.svh"

module ihrp_port import ihrp_pkg::*; #(
  parameter int MEM_ADDR_W = 8
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_host_chip_select_n,
  input wire logic i_host_read_not_write,
  input wire logic i_host_reg_select_hi,
  input wire logic i_host_reg_select_lo,
  input wire logic [7:0] i_host_data,
  input wire logic i_internal_busy,
  input wire logic i_test_reset_n,
  input wire logic i_test_clock,
  input wire logic i_test_mode,
  input wire logic i_test_din,
  output logic [7:0] o_host_data,
  output logic o_host_data_oe,
  output logic o_host_ready_low,
  output logic o_host_ready_low_oe,
  output logic [47:0] o_node_addr,
  output logic o_node_is_group,
  output logic o_node_is_local,
  output logic o_test_dout
);

  // refused at elaboration: the array index is cut from the 16-bit pointer
  if (MEM_ADDR_W < 8 || MEM_ADDR_W > 16) begin : g_bad_width
    $error("ihrp_port: internal address width out of range");
  end

  localparam int PIN_W = $bits(ihrp_pins_s);
  localparam logic [2:0] SLOT_LAST = 3'(`IHRP_SLOT_COUNT - 1);
  localparam logic [2:0] SLOT_HOST = 3'(`IHRP_HOST_SLOTS);
  localparam logic [2:0] WAIT_MAX = 3'(`IHRP_HOST_WAIT_CYC);

  // ---------------------------------------------------------------
  // host pin synchroniser: three stages, change taken when 2 and 3 agree
  // ---------------------------------------------------------------
  ihrp_pins_s raw_pins;
  logic [PIN_W-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  ihrp_pins_s pins;

  assign raw_pins.cs_n = i_host_chip_select_n;
  assign raw_pins.read_not_write = i_host_read_not_write;
  assign raw_pins.sel = {i_host_reg_select_hi, i_host_reg_select_lo};
  assign raw_pins.data = i_host_data;

  for (genvar b = 0; b < PIN_W; b++) begin : g_filter
    assign filt_d[b] = (s2_q[b] == s3_q[b]) ? s3_q[b] : filt_q[b];
  end

  // deselected idle level keeps a spurious cycle from starting
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s1_q <= {1'b1, {(PIN_W-1){1'b0}}};
      s2_q <= {1'b1, {(PIN_W-1){1'b0}}};
      s3_q <= {1'b1, {(PIN_W-1){1'b0}}};
      filt_q <= {1'b1, {(PIN_W-1){1'b0}}};
    end else begin
      s1_q <= raw_pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  assign pins = ihrp_pins_s'(filt_q);

  // ---------------------------------------------------------------
  // device reset: pin reset or the special address-high pattern
  // ---------------------------------------------------------------
  logic hw_reset_q, hw_reset_d;
  logic rst_all;

  assign rst_all = i_reset | hw_reset_q;

  // ---------------------------------------------------------------
  // access slot arbiter
  // ---------------------------------------------------------------
  logic [2:0] slot_q, slot_d;
  logic [2:0] wait_q, wait_d;
  logic grant;

  // host owns slots 0 and 1
  always_comb begin
    slot_d = (slot_q == SLOT_LAST) ? 3'h0 : slot_q + 3'h1;
  end
  always_ff @(posedge i_clock) begin
    if (rst_all) begin
      slot_q <= 3'h0;
    end else begin
      slot_q <= slot_d;
    end
  end

  assign grant = (slot_q < SLOT_HOST) || !i_internal_busy ||
                 (wait_q >= WAIT_MAX);

  // ---------------------------------------------------------------
  // host cycle sequencer and pointer registers
  // ---------------------------------------------------------------
  ihrp_state_e st_q, st_d;
  logic [15:0] addr_q, addr_d;
  logic [1:0] sel_q, sel_d;
  logic rnw_q, rnw_d;
  logic [7:0] wdat_q, wdat_d;
  logic [7:0] dout_q, dout_d;
  logic ok_q, ok_d;
  logic rdy_q, rdy_d;
  logic rdy_oe_q, rdy_oe_d;
  logic doe_q, doe_d;
  logic soft_q, soft_d;
  logic [47:0] node_q, node_d;
  logic mem_we;
  logic [7:0] mem_rdata;
  logic [15:0] node_off;

  assign node_off = addr_q - `IHRP_NODE_BASE;

  always_comb begin
    st_d = st_q;
    addr_d = addr_q;
    sel_d = sel_q;
    rnw_d = rnw_q;
    wdat_d = wdat_q;
    dout_d = dout_q;
    ok_d = ok_q;
    rdy_d = rdy_q;
    wait_d = wait_q;
    node_d = node_q;
    hw_reset_d = 1'b0;
    soft_d = 1'b0;
    mem_we = 1'b0;
    case (st_q)
      // a cycle seen across a reset is let go before the next one
      ST_RELEASE: begin
        if (pins.cs_n) st_d = ST_IDLE;
      end
      ST_IDLE: begin
        if (!pins.cs_n) begin
          sel_d = pins.sel;
          rnw_d = pins.read_not_write;
          wdat_d = pins.data;
          wait_d = 3'h0;
          if (pins.sel == `IHRP_SEL_ADDR_LOW) begin
            if (pins.read_not_write) begin
              dout_d = addr_q[7:0];
              ok_d = 1'b1;
            end else begin
              addr_d[7:0] = pins.data;
            end
            rdy_d = 1'b0;
            st_d = ST_DONE;
          end else if (pins.sel == `IHRP_SEL_ADDR_HIGH) begin
            if (pins.read_not_write) begin
              dout_d = addr_q[15:8];
              ok_d = 1'b1;
            end else if (pins.data == `IHRP_HW_RESET_PATTERN) begin
              hw_reset_d = 1'b1;
            end else begin
              addr_d[15:8] = pins.data;
            end
            // the reset write is never acknowledged; the host times out
            rdy_d = hw_reset_d;
            st_d = ST_DONE;
          end else begin
            st_d = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (grant) begin
          if (rnw_q) begin
            st_d = ST_FETCH;
          end else begin
            mem_we = 1'b1;
            if (addr_q == `IHRP_CTRL_INDEX &&
                wdat_q[`IHRP_CTRL_SOFT_RESET_BIT]) begin
              soft_d = 1'b1;
            end
            for (int i = 0; i < `IHRP_NODE_BYTES; i++) begin
              if (node_off == 16'(i)) node_d[47 - 8 * i -: 8] = wdat_q;
            end
            rdy_d = 1'b0;
            if (sel_q == `IHRP_SEL_DATA_INC) addr_d = addr_q + `IHRP_ADDR_STEP;
            st_d = ST_DONE;
          end
        end else begin
          wait_d = wait_q + 3'h1;
        end
      end
      ST_FETCH: begin
        dout_d = mem_rdata;
        ok_d = 1'b1;
        rdy_d = 1'b0;
        if (sel_q == `IHRP_SEL_DATA_INC) addr_d = addr_q + `IHRP_ADDR_STEP;
        st_d = ST_DONE;
      end
      ST_DONE: begin
        if (pins.cs_n) begin
          rdy_d = 1'b1;
          ok_d = 1'b0;
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_RELEASE;
    endcase
    // soft reset also clears the shadowed node copy
    if (soft_q) node_d = 48'h0000_0000_0000;
    rdy_oe_d = !pins.cs_n;
    // data driven from the read result until chip select rises
    doe_d = !pins.cs_n && rnw_d && ok_d;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      hw_reset_q <= 1'b0;
    end else begin
      hw_reset_q <= hw_reset_d;
    end
  end

  // every register to default on either reset
  always_ff @(posedge i_clock) begin
    if (rst_all) begin
      st_q <= ST_RELEASE;
      addr_q <= `IHRP_ADDR_RESET;
      sel_q <= `IHRP_SEL_ADDR_LOW;
      rnw_q <= 1'b0;
      wdat_q <= `IHRP_DEFAULT_VALUE;
      dout_q <= `IHRP_DEFAULT_VALUE;
      ok_q <= 1'b0;
      rdy_q <= 1'b1;
      rdy_oe_q <= 1'b0;
      doe_q <= 1'b0;
      wait_q <= 3'h0;
      soft_q <= 1'b0;
      node_q <= 48'h0000_0000_0000;
    end else begin
      st_q <= st_d;
      addr_q <= addr_d;
      sel_q <= sel_d;
      rnw_q <= rnw_d;
      wdat_q <= wdat_d;
      dout_q <= dout_d;
      ok_q <= ok_d;
      rdy_q <= rdy_d;
      rdy_oe_q <= rdy_oe_d;
      doe_q <= doe_d;
      wait_q <= wait_d;
      soft_q <= soft_d;
      node_q <= node_d;
    end
  end

  // ---------------------------------------------------------------
  // internal registers; addresses above the array alias into it
  // ---------------------------------------------------------------
  ihrp_reg_mem #(
    .ADDR_W(MEM_ADDR_W),
    .DATA_W(8)
  ) u_mem (
    .i_clock(i_clock),
    .i_clear_all(rst_all),
    .i_clear_soft(soft_q),
    .i_keep_index(MEM_ADDR_W'(`IHRP_CTRL_INDEX)),
    .i_write(mem_we),
    .i_addr(addr_q[MEM_ADDR_W-1:0]),
    .i_wdata(wdat_q),
    .o_rdata(mem_rdata)
  );

  // ---------------------------------------------------------------
  // test port
  // ---------------------------------------------------------------
  ihrp_test_port u_tap (
    .i_clock(i_clock),
    .i_test_reset_n(i_test_reset_n),
    .i_test_clock(i_test_clock),
    .i_test_mode(i_test_mode),
    .i_test_din(i_test_din),
    .o_test_dout(o_test_dout)
  );

  assign o_host_data = dout_q;
  assign o_host_data_oe = doe_q;
  assign o_host_ready_low = rdy_q;
  assign o_host_ready_low_oe = rdy_oe_q;
  assign o_node_addr = node_q;
  assign o_node_is_group = node_q[`IHRP_NODE_GROUP_BIT];
  assign o_node_is_local = node_q[`IHRP_NODE_LOCAL_BIT];

endmodule // ihrp_port

// File: testbench/ihrp_port_assertions.sv
// concurrent checks on the host register port pins
module ihrp_port_assertions (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_host_chip_select_n,
  input wire logic i_host_read_not_write,
  input wire logic i_test_reset_n,
  input wire logic o_host_data_oe,
  input wire logic o_host_ready_low,
  input wire logic o_host_ready_low_oe,
  input wire logic [47:0] o_node_addr,
  input wire logic o_node_is_group,
  input wire logic o_node_is_local,
  input wire logic o_test_dout
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  // ------------------------------------------------------------
  // host cycle timing
  // ------------------------------------------------------------
  // defaults after reset
  property p_reset_dflt;
    $fell(i_reset) |-> o_host_ready_low && !o_host_ready_low_oe &&
      !o_host_data_oe && o_node_addr == 48'h0000_0000_0000;
  endproperty
  a_reset_dflt: assert property (p_reset_dflt)
    else $error("outputs not at defaults after reset");
  property p_ready_z;
    i_host_chip_select_n [*6] |-> !o_host_ready_low_oe;
  endproperty
  a_ready_z: assert property (p_ready_z)
    else $error("ready driven while deselected");
  property p_ready_cause;
    $fell(o_host_ready_low) |-> $past(i_host_chip_select_n, 1) == 1'b0 &&
      $past(i_host_chip_select_n, 5) == 1'b0;
  endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready low without a held host cycle");
  property p_read_bound;
    $fell(i_host_chip_select_n) && i_host_read_not_write
      ##1 !i_host_chip_select_n [*7]
      |=> !o_host_ready_low;
  endproperty
  a_read_bound: assert property (p_read_bound)
    else $error("read ready later than the bound");
  property p_read_oe;
    o_host_data_oe |-> i_host_read_not_write && !o_host_ready_low;
  endproperty
  a_read_oe: assert property (p_read_oe)
    else $error("data driven outside a finished read");
  property p_ready_end;
    $rose(o_host_ready_low) |-> $past(i_host_chip_select_n, 1) &&
      $past(i_host_chip_select_n, 3);
  endproperty
  a_ready_end: assert property (p_ready_end)
    else $error("ready withdrawn while cycle held");

  // ------------------------------------------------------------
  // node flags and test port
  // ------------------------------------------------------------
  // group flag position
  property p_group;
    o_node_is_group == o_node_addr[40];
  endproperty
  a_group: assert property (p_group)
    else $error("group flag not at bit 40");
  property p_local;
    o_node_is_local == o_node_addr[41];
  endproperty
  a_local: assert property (p_local)
    else $error("local flag not at bit 41");
  property p_test_rst;
    !i_test_reset_n |-> !o_test_dout;
  endproperty
  a_test_rst: assert property (p_test_rst)
    else $error("test output not cleared by test reset");
endmodule // ihrp_port_assertions

bind ihrp_port ihrp_port_assertions u_ihrp_port_assertions (
  .i_clock(i_clock),
  .i_reset(i_reset),
  .i_host_chip_select_n(i_host_chip_select_n),
  .i_host_read_not_write(i_host_read_not_write),
  .i_test_reset_n(i_test_reset_n),
  .o_host_data_oe(o_host_data_oe),
  .o_host_ready_low(o_host_ready_low),
  .o_host_ready_low_oe(o_host_ready_low_oe),
  .o_node_addr(o_node_addr),
  .o_node_is_group(o_node_is_group),
  .o_node_is_local(o_node_is_local),
  .o_test_dout(o_test_dout)
);

// File: testbench/ihrp_host_model.sv
// management host model: drives the host port pins, resolves shared lines
module ihrp_host_model (
  input wire logic i_clock,
  input wire logic [7:0] i_dev_data,
  input wire logic i_dev_data_oe,
  input wire logic i_dev_ready_low,
  input wire logic i_dev_ready_low_oe,
  output logic o_cs_n,
  output logic o_rnw,
  output logic [1:0] o_sel,
  output logic [7:0] o_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drive_q;
  logic [7:0] wd_q;
  logic [7:0] last_q;
  logic ready_w;

  // released ready line sits at its pull-up
  assign ready_w = i_dev_ready_low_oe ? i_dev_ready_low : 1'b1;
  // an undriven bus shows the inverse of its last level
  assign o_bus = drive_q ? wd_q : (i_dev_data_oe ? i_dev_data : ~last_q);
  always @(posedge i_clock) begin
    last_q <= o_bus;
  end

  initial begin
    o_cs_n = 1'b1;
    o_rnw = 1'b1;
    o_sel = 2'h0;
    drive_q = 1'b0;
    wd_q = 8'h00;
    last_q = 8'h00;
  end

  // one cycle, ended on ready or by a limit
  task automatic cycle(input logic rd, input logic [1:0] sel,
      input logic [7:0] wd, output logic [7:0] rdat, output logic done);
    int n;
    @(posedge i_clock);
    o_cs_n <= 1'b0;
    o_rnw <= rd;
    o_sel <= sel;
    wd_q <= wd;
    drive_q <= !rd;
    n = 0;
    done = 1'b0;
    while (!done && n < 16) begin
      @(posedge i_clock);
      n++;
      done = (ready_w === 1'b0);
    end
    rdat = o_bus;
    o_cs_n <= 1'b1;
    drive_q <= 1'b0;
    // the port must see chip select high before the next cycle
    repeat (6) @(posedge i_clock);
  endtask
endmodule // ihrp_host_model

// File: testbench/tb.sv
// self-checking bench for the indirect host register port
`include "ihrp_map.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [47:0] NODE_EXP = 48'h0311_2233_4455;
  logic i_clock, i_reset, i_internal_busy, i_test_reset_n;
  logic cs_n, rnw, dout_oe, rdy, rdy_oe, grp, loc, tdo, ok;
  logic [1:0] sel;
  logic [7:0] bus, dout, r;
  logic [47:0] node;
  int fail_count, n_tests;

  ihrp_port u_ihrp_port (.i_clock(i_clock), .i_reset(i_reset),
    .i_host_chip_select_n(cs_n), .i_host_read_not_write(rnw),
    .i_host_reg_select_hi(sel[1]), .i_host_reg_select_lo(sel[0]),
    .i_host_data(bus), .i_internal_busy(i_internal_busy),
    .i_test_reset_n(i_test_reset_n), .i_test_clock(1'b0),
    .i_test_mode(1'b1), .i_test_din(1'b0), .o_host_data(dout),
    .o_host_data_oe(dout_oe), .o_host_ready_low(rdy),
    .o_host_ready_low_oe(rdy_oe), .o_node_addr(node),
    .o_node_is_group(grp), .o_node_is_local(loc), .o_test_dout(tdo));

  ihrp_host_model u_ihrp_host_model (.i_clock(i_clock),
    .i_dev_data(dout), .i_dev_data_oe(dout_oe), .i_dev_ready_low(rdy),
    .i_dev_ready_low_oe(rdy_oe), .o_cs_n(cs_n), .o_rnw(rnw),
    .o_sel(sel), .o_bus(bus));

  // 10 MHz clock
  always #50 i_clock = ~i_clock;

  // ------------------------------------------------------------
  // compare, access and closing tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [47:0] seen,
      input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic hw(input logic [1:0] s, input logic [7:0] d);
    logic [7:0] x;
    logic k;
    u_ihrp_host_model.cycle(1'b0, s, d, x, k);
    check("write ready", 48'(k), 48'(1'b1));
  endtask

  task automatic hr(input logic [1:0] s, input logic [7:0] e,
      input string what);
    logic [7:0] x;
    logic k;
    u_ihrp_host_model.cycle(1'b1, s, 8'h00, x, k);
    check("read ready", 48'(k), 48'(1'b1));
    check(what, 48'(x), 48'(e));
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge i_clock);
    fail_count++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    i_reset = 1'b1;
    i_internal_busy = 1'b0;
    i_test_reset_n = 1'b0;
    fail_count = 0;
    n_tests = 0;
    repeat (6) @(posedge i_clock);
    i_reset <= 1'b0;
    @(posedge i_clock);
    check("test dout", 48'(tdo), 48'(1'b0));
    i_test_reset_n <= 1'b1;
    hw(`IHRP_SEL_ADDR_LOW, 8'h0C);
    hw(`IHRP_SEL_ADDR_HIGH, 8'h00);
    for (int i = 0; i < 6; i++) begin
      hw(`IHRP_SEL_DATA_INC, NODE_EXP[47-8*i -: 8]);
    end
    check("node", node, NODE_EXP);
    check("group", 48'(grp), 48'(NODE_EXP[40]));
    check("local", 48'(loc), 48'(NODE_EXP[41]));
    hr(`IHRP_SEL_ADDR_LOW, 8'h12, "addr low after six");
    // mixed directions all increment, plain window does not
    hw(`IHRP_SEL_ADDR_LOW, 8'h0C);
    hr(`IHRP_SEL_DATA_INC, 8'h03, "inc read 0c");
    hw(`IHRP_SEL_DATA_INC, 8'hA6);
    hr(`IHRP_SEL_DATA_INC, 8'h22, "inc read 0e");
    hr(`IHRP_SEL_DATA, 8'h33, "plain read 0f");
    hr(`IHRP_SEL_DATA, 8'h33, "plain read again");
    check("node after write", node, 48'h03A6_2233_4455);
    // carry into high byte while resource busy
    i_internal_busy <= 1'b1;
    hw(`IHRP_SEL_ADDR_LOW, 8'hFF);
    hr(`IHRP_SEL_DATA_INC, 8'h00, "read at ff");
    hr(`IHRP_SEL_ADDR_LOW, 8'h00, "low after carry");
    hr(`IHRP_SEL_ADDR_HIGH, 8'h01, "high after carry");
    i_internal_busy <= 1'b0;
    // soft reset spares the control register
    hw(`IHRP_SEL_ADDR_LOW, 8'h08);
    hw(`IHRP_SEL_ADDR_HIGH, 8'h00);
    hw(`IHRP_SEL_DATA, 8'h01);
    check("node after soft", node, 48'h0000_0000_0000);
    hr(`IHRP_SEL_DATA, 8'h01, "control kept");
    // reset pattern, address low is a don't care
    hw(`IHRP_SEL_ADDR_LOW, 8'h77);
    u_ihrp_host_model.cycle(1'b0, `IHRP_SEL_ADDR_HIGH,
      `IHRP_HW_RESET_PATTERN, r, ok);
    check("reset write ready", 48'(ok), 48'(1'b0));
    hr(`IHRP_SEL_ADDR_LOW, 8'h00, "low after reset");
    hr(`IHRP_SEL_ADDR_HIGH, 8'h00, "high after reset");
    hw(`IHRP_SEL_ADDR_LOW, 8'h08);
    hr(`IHRP_SEL_DATA, 8'h00, "control cleared");
    end_of_test();
  end
endmodule // tb
